// ==== sbcc_regs.svh ====
`ifndef SBCC_REGS_SVH
`define SBCC_REGS_SVH

// ==========================================================
// register offsets
`define SBCC_OFF_BREAK_STATUS    16'hfe00
`define SBCC_OFF_RESET_CAUSE     16'hfe01
`define SBCC_OFF_BREAK_FLAG_CTRL 16'hfe03
`define SBCC_OFF_CLOCK_CTRL      16'hfe04
`define SBCC_OFF_CLOCK_STATUS    16'hfe05
`define SBCC_OFF_IRQ_PENDING0    16'hfe08

// ==========================================================
// field positions
`define SBCC_CTRL_SHORT_STOP_RECOVERY_SEL_BIT   0
`define SBCC_CTRL_STOP_BIT    1
`define SBCC_CTRL_WAIT_BIT    2
`define SBCC_RC_POR_BIT       7
`define SBCC_RC_PIN_BIT       6
`define SBCC_RC_LVI_BIT       1
`define SBCC_BS_BW_BIT        1
`define SBCC_BFC_BCFE_BIT     7

// ==========================================================
// reset values
`define SBCC_RST_BREAK_STATUS 8'h00
`define SBCC_RST_BFC          8'h00
`define SBCC_RST_CTRL         8'h00
`define SBCC_RST_CAUSE        8'h80

// ==========================================================
// timing counts in reference cycles
`define SBCC_POR_HOLD_CYCLES   4096
`define SBCC_STOP_LONG_CYCLES  4096
`define SBCC_STOP_SHORT_CYCLES 32
`define SBCC_CNT_WIDTH         12

`endif

// ==== sbcc_pkg.sv ====
package sbcc_pkg;
    // ==========================================================
    // recovery sequencer states
    typedef enum logic [3:0]
    {
        SBCC_HOLD_POR = 4'b0001,
        SBCC_RUN      = 4'b0010,
        SBCC_STOPPED  = 4'b0100,
        SBCC_WAITING  = 4'b1000
    } sbcc_state_t;
endpackage : sbcc_pkg

// ==== sbcc_phase_gen.sv ====
`timescale 1ns/1ps
// two non-overlapping bus phases from the generator output
module sbcc_phase_gen
(
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_resetn,
    // control
    input  wire logic i_gen_out,
    input  wire logic i_run,
    // phases
    output logic      o_phase1,
    output logic      o_phase2
);
    logic sync_a;
    logic sync_b;
    logic last_gen;
    logic div2;
    logic next_div2;
    logic next_phase1;
    logic next_phase2;

    // ==========================================================
    // divide the generator output by two
    always_comb
    begin
        next_div2 = div2;
        if (sync_b && !last_gen)
            next_div2 = ~div2;
        // one dead step between phases keeps them apart
        next_phase1 = i_run && div2 && !o_phase2 && !next_div2 ? 1'b0
                      : i_run && div2 && !o_phase2;
        next_phase2 = i_run && !div2 && !o_phase1 && next_div2 == div2;
    end

    // register stage
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sync_a   <= 1'b0;
            sync_b   <= 1'b0;
            last_gen <= 1'b0;
            div2     <= 1'b0;
            o_phase1 <= 1'b0;
            o_phase2 <= 1'b0;
        end
        else
        begin
            sync_a   <= i_gen_out;
            sync_b   <= sync_a;
            last_gen <= sync_b;
            div2     <= next_div2;
            o_phase1 <= next_phase1;
            o_phase2 <= next_phase2;
        end
    end
endmodule : sbcc_phase_gen

// ==== sbcc_clock_control.sv ====
`timescale 1ns/1ps
`include "sbcc_regs.svh"
module sbcc_clock_control
    import sbcc_pkg::*;
#(
    parameter int POR_HOLD_CYCLES  = `SBCC_POR_HOLD_CYCLES,
    parameter int STOP_LONG_CYCLES = `SBCC_STOP_LONG_CYCLES,
    parameter int IRQ_COUNT        = 32
)
(
    // clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_resetn,
    // clock generator side
    input  wire logic                 i_osc_ref_clock,
    input  wire logic                 i_clock_gen_output,
    input  wire logic                 i_pll_select,
    // reset sources
    input  wire logic                 i_power_on_pulse,
    input  wire logic                 i_low_voltage_trip,
    input  wire logic                 i_reset_pin,
    // cpu side
    input  wire logic                 i_stop_exec,
    input  wire logic                 i_wait_exec,
    input  wire logic                 i_break,
    input  wire logic [IRQ_COUNT-1:0] i_irq,
    // register port
    input  wire logic [15:0]          i_addr,
    input  wire logic [7:0]           i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [7:0]           o_rdata,
    // clock and reset outputs
    output logic                      o_cpu_clock_en,
    output logic                      o_periph_clock_en,
    output logic                      o_bus_phase1,
    output logic                      o_bus_phase2,
    output logic                      o_pll_select,
    output logic                      o_reset_pin_out,
    output logic                      o_reset_pin_oe_n,
    output logic                      o_internal_reset,
    output logic                      o_irq_any
);
    // ==========================================================
    // synchronisers for foreign inputs
    logic [1:0] osc_sync;
    logic [1:0] por_sync;
    logic [1:0] lvi_sync;
    logic [1:0] pin_sync;
    logic [IRQ_COUNT-1:0] irq_s1;
    logic [IRQ_COUNT-1:0] irq_s2;
    logic       osc_last;

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            osc_sync <= 2'h0;
            por_sync <= 2'h0;
            lvi_sync <= 2'h0;
            pin_sync <= 2'h3;
            irq_s1   <= '0;
            irq_s2   <= '0;
            osc_last <= 1'b0;
        end
        else
        begin
            osc_sync <= {osc_sync[0], i_osc_ref_clock};
            por_sync <= {por_sync[0], i_power_on_pulse};
            lvi_sync <= {lvi_sync[0], i_low_voltage_trip};
            pin_sync <= {pin_sync[0], i_reset_pin};
            irq_s1   <= i_irq;
            irq_s2   <= irq_s1;
            osc_last <= osc_sync[1];
        end
    end

    // falling edge of the reference clock advances the counter
    logic osc_fall;
    assign osc_fall = osc_last && !osc_sync[1];

    // ==========================================================
    // registers and state
    sbcc_state_t               state;
    sbcc_state_t               next_state;
    logic [`SBCC_CNT_WIDTH:0]  count;
    logic [`SBCC_CNT_WIDTH:0]  next_count;
    logic [7:0]                ctrl;
    logic [7:0]                next_ctrl;
    logic [7:0]                brk_status;
    logic [7:0]                next_brk_status;
    logic [7:0]                bfc;
    logic [7:0]                next_bfc;
    logic [7:0]                cause;
    logic [7:0]                next_cause;
    logic [7:0]                next_rdata;
    logic                      stop_short;
    logic [`SBCC_CNT_WIDTH:0]  stop_limit;
    logic                      irq_wake;

    // 32 pending sources, any mix of external and internal
    assign irq_wake   = |irq_s2;
    assign stop_short = ctrl[`SBCC_CTRL_SHORT_STOP_RECOVERY_SEL_BIT];
    // short recovery only when the select bit is one
    assign stop_limit = stop_short ?
        (`SBCC_CNT_WIDTH+1)'(`SBCC_STOP_SHORT_CYCLES) :
        (`SBCC_CNT_WIDTH+1)'(STOP_LONG_CYCLES);

    // register read decode, reused for write decode
    function automatic logic sbcc_hit(input logic [15:0] a,
                                      input logic [15:0] off);
        sbcc_hit = (a == off);
    endfunction : sbcc_hit

    function automatic logic [7:0] sbcc_irq_byte(
        input logic [IRQ_COUNT-1:0] v, input logic [15:0] a);
        logic [IRQ_COUNT+7:0] w;
        w = {8'h00, v};
        sbcc_irq_byte = w[8*a[1:0] +: 8];
    endfunction : sbcc_irq_byte

    // ==========================================================
    // sequencer next state
    always_comb
    begin
        next_state      = state;
        next_count      = count;
        next_ctrl       = ctrl;
        next_brk_status = brk_status;
        next_bfc        = bfc;
        next_cause      = cause;
        case (state)
            SBCC_HOLD_POR:
            begin
                // clocks held, counting reference cycles
                if (osc_fall)
                    next_count = count + 1'b1;
                if (count >= (`SBCC_CNT_WIDTH+1)'(POR_HOLD_CYCLES))
                begin
                    next_state = SBCC_RUN;
                    next_count = '0;
                end
            end
            SBCC_RUN:
            begin
                // free running prescaler between events
                if (osc_fall)
                    next_count = count + 1'b1;
                if (i_stop_exec)
                begin
                    next_state = SBCC_STOPPED;
                    next_count = '0;
                end
                else if (i_wait_exec)
                    next_state = SBCC_WAITING;
            end
            SBCC_STOPPED:
            begin
                // wake source lets the reference drive the counter
                if ((irq_wake || i_break || ctrl[`SBCC_CTRL_STOP_BIT])
                    && osc_fall)
                    next_count = count + 1'b1;
                if (count >= stop_limit)
                begin
                    next_state = SBCC_RUN;
                    next_count = '0;
                end
                else if (count == '0 && !(irq_wake || i_break
                         || ctrl[`SBCC_CTRL_STOP_BIT]))
                    next_count = '0;
            end
            SBCC_WAITING:
            begin
                if (irq_wake || i_break)
                    next_state = SBCC_RUN;
            end
            default:
            begin
                next_state = SBCC_HOLD_POR;
                next_count = '0;
            end
        endcase
        // low voltage trip restarts the long hold-off
        if (por_sync[1] || lvi_sync[1])
        begin
            next_state = SBCC_HOLD_POR;
            next_count = '0;
            next_cause = por_sync[1] ?
                8'h01 << `SBCC_RC_POR_BIT : cause;
            if (lvi_sync[1])
                next_cause[`SBCC_RC_LVI_BIT] = 1'b1;
        end
        if (!pin_sync[1])
            next_cause[`SBCC_RC_PIN_BIT] = 1'b1;
        if (i_break)
            next_brk_status[`SBCC_BS_BW_BIT] = 1'b1;
        // software writes; the stop wake bit clears itself
        if (state != SBCC_STOPPED)
            next_ctrl[`SBCC_CTRL_STOP_BIT] = 1'b0;
        if (i_wr && sbcc_hit(i_addr, `SBCC_OFF_CLOCK_CTRL))
            next_ctrl = i_wdata;
        if (i_wr && sbcc_hit(i_addr, `SBCC_OFF_BREAK_FLAG_CTRL))
            next_bfc = i_wdata;
        // break flag clears by writing zero, set wins
        if (i_wr && sbcc_hit(i_addr, `SBCC_OFF_BREAK_STATUS) && !i_break)
            next_brk_status[`SBCC_BS_BW_BIT] =
                brk_status[`SBCC_BS_BW_BIT] & i_wdata[`SBCC_BS_BW_BIT];
        // reading the cause register clears it
        if (i_rd && sbcc_hit(i_addr, `SBCC_OFF_RESET_CAUSE)
            && !(por_sync[1] || lvi_sync[1]) && pin_sync[1])
            next_cause = 8'h00;
    end

    // read data mux
    always_comb
    begin
        next_rdata = 8'h00;
        if (i_rd)
        begin
            if (sbcc_hit(i_addr, `SBCC_OFF_BREAK_STATUS))
                next_rdata = brk_status;
            else if (sbcc_hit(i_addr, `SBCC_OFF_RESET_CAUSE))
                next_rdata = cause;
            else if (sbcc_hit(i_addr, `SBCC_OFF_BREAK_FLAG_CTRL))
                next_rdata = bfc;
            else if (sbcc_hit(i_addr, `SBCC_OFF_CLOCK_CTRL))
                next_rdata = ctrl;
            else if (sbcc_hit(i_addr, `SBCC_OFF_CLOCK_STATUS))
                next_rdata = {4'h0, state};
            else if (i_addr[15:2] == 14'(`SBCC_OFF_IRQ_PENDING0 >> 2))
                next_rdata = sbcc_irq_byte(irq_s2, i_addr);
        end
    end

    // state registers
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state      <= SBCC_HOLD_POR;
            count      <= '0;
            ctrl       <= `SBCC_RST_CTRL;
            brk_status <= `SBCC_RST_BREAK_STATUS;
            bfc        <= `SBCC_RST_BFC;
            cause      <= `SBCC_RST_CAUSE;
            o_rdata    <= 8'h00;
        end
        else
        begin
            state      <= next_state;
            count      <= next_count;
            ctrl       <= next_ctrl;
            brk_status <= next_brk_status;
            bfc        <= next_bfc;
            cause      <= next_cause;
            o_rdata    <= next_rdata;
        end
    end

    // ==========================================================
    // clock enables and reset pin
    logic run_bus;
    assign run_bus = (state == SBCC_RUN) || (state == SBCC_WAITING);
    // cpu stops in wait, peripherals keep bus, own gating applies
    assign o_cpu_clock_en    = (state == SBCC_RUN);
    assign o_periph_clock_en = run_bus;
    // pin pulled low through the whole hold-off
    assign o_reset_pin_out   = 1'b0;
    assign o_reset_pin_oe_n  = (state != SBCC_HOLD_POR);
    assign o_internal_reset  = (state == SBCC_HOLD_POR);
    // select passed to the generator's glitch-free mux
    assign o_pll_select      = i_pll_select;
    assign o_irq_any         = irq_wake;

    // bus at generator/2; generator is source/2, so source/4
    sbcc_phase_gen u_phase
    (
        .i_clock   (i_clock),
        .i_resetn  (i_resetn),
        .i_gen_out (i_clock_gen_output),
        .i_run     (run_bus),
        .o_phase1  (o_bus_phase1),
        .o_phase2  (o_bus_phase2)
    );
endmodule : sbcc_clock_control

// ==== sbcc_cpu_model.sv ====
`timescale 1ns/1ps
// ==========================================
// cpu stand-in: runs stop or wait on command
module sbcc_cpu_model
(
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    // clock from the block and bench command
    input  wire logic       i_cpu_clock_en,
    input  wire logic [1:0] i_cmd,
    // instruction strobes
    output logic            o_stop_exec,
    output logic            o_wait_exec
);
    // a halted cpu executes nothing, so strobes need its clock
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            {o_stop_exec, o_wait_exec} <= 2'b00;
        else
            {o_stop_exec, o_wait_exec} <= i_cpu_clock_en ?
                {i_cmd == 2'h1, i_cmd == 2'h2} : 2'b00;
    end
endmodule : sbcc_cpu_model

// ==== sbcc_asserts.sv ====
`timescale 1ns/1ps
// ==========================================
// port checker for the clock control block
module sbcc_asserts
#(
    parameter int POR_HOLD_CYCLES = 64,
    parameter int IRQ_COUNT       = 32
)
(
    // watched ports
    input wire logic                 i_clock,
    input wire logic                 i_resetn,
    input wire logic                 i_osc_ref_clock,
    input wire logic                 i_pll_select,
    input wire logic                 i_stop_exec,
    input wire logic                 i_wait_exec,
    input wire logic                 i_break,
    input wire logic [IRQ_COUNT-1:0] i_irq,
    input wire logic                 i_rd,
    input wire logic [7:0]           o_rdata,
    input wire logic                 o_cpu_clock_en,
    input wire logic                 o_periph_clock_en,
    input wire logic                 o_bus_phase1,
    input wire logic                 o_bus_phase2,
    input wire logic                 o_pll_select,
    input wire logic                 o_reset_pin_oe_n,
    input wire logic                 o_internal_reset
);
    logic        ref_q;
    logic [12:0] falls;
    // reference falls seen during hold-off, restarted outside it
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ref_q <= 1'b0;
            falls <= 13'h0;
        end
        else
        begin
            ref_q <= i_osc_ref_clock;
            falls <= o_internal_reset ?
                falls + 13'(ref_q & ~i_osc_ref_clock) : 13'h0;
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    // ==========================================
    // assertions
    chk_pll_pass: assert property (o_pll_select == i_pll_select)
        else $error("pll select differs");
    chk_phase_overlap: assert property (
        !(o_bus_phase1 && o_bus_phase2))
        else $error("bus phases overlap");
    chk_holdoff_quiet: assert property (o_internal_reset |->
        !o_reset_pin_oe_n && !o_cpu_clock_en && !o_periph_clock_en)
        else $error("clocks or pin wrong in hold-off");
    chk_holdoff_len: assert property (
        $fell(o_internal_reset) |->
        falls >= POR_HOLD_CYCLES - 3 && falls <= POR_HOLD_CYCLES + 3)
        else $error("hold-off length wrong");
    chk_run_start: assert property ($fell(o_internal_reset) |->
        o_cpu_clock_en && o_periph_clock_en)
        else $error("clocks late after hold-off");
    chk_stop_off: assert property (i_stop_exec && o_cpu_clock_en |=>
        (!o_cpu_clock_en && !o_periph_clock_en)[*8])
        else $error("clocks running in stop");
    chk_wait_cpu: assert property (i_wait_exec && o_cpu_clock_en &&
        !i_break && i_irq == '0 |=> !o_cpu_clock_en && o_periph_clock_en)
        else $error("wait clocks wrong");
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule : sbcc_asserts

bind sbcc_clock_control sbcc_asserts #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES),
    .IRQ_COUNT(IRQ_COUNT)) i_sbcc_asserts (.i_clock(i_clock),
    .i_resetn(i_resetn), .i_osc_ref_clock(i_osc_ref_clock),
    .i_pll_select(i_pll_select), .i_stop_exec(i_stop_exec),
    .i_wait_exec(i_wait_exec), .i_break(i_break), .i_irq(i_irq),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_cpu_clock_en(o_cpu_clock_en),
    .o_periph_clock_en(o_periph_clock_en), .o_bus_phase1(o_bus_phase1),
    .o_bus_phase2(o_bus_phase2), .o_pll_select(o_pll_select),
    .o_reset_pin_oe_n(o_reset_pin_oe_n),
    .o_internal_reset(o_internal_reset));

// ==== testbench.sv ====
`timescale 1ns/1ps
// ==========================================
// bench for the clock control block
module testbench;
    logic        clk = 0, rstn = 0, osc = 0, gen = 0, pll = 0;
    logic        brk = 0, wr_s = 0, rd_s = 0, stp, wt, any;
    logic        cpu_en, per_en, ph1, ph2, psel, poe_n, internal_reset, pout;
    logic [1:0]  src = 0, cmd = 0;
    logic [31:0] irq = 0;
    logic [15:0] addr = 0;
    logic [7:0]  wdata = 0, rdata;
    int          errors = 0, samples_checked = 0;

    // reference period is four clocks; generator is the reference / 2,
    // as the divide-by-two source stage gives, phases unrelated
    initial forever #5 clk = ~clk;
    initial forever #20 osc = ~osc;
    initial #3 forever #40 gen = ~gen;

    sbcc_clock_control #(.POR_HOLD_CYCLES(64), .STOP_LONG_CYCLES(64))
    i_sbcc_clock_control
    (
        .i_clock(clk), .i_resetn(rstn), .i_osc_ref_clock(osc),
        .i_clock_gen_output(gen), .i_pll_select(pll),
        .i_power_on_pulse(src[1]), .i_low_voltage_trip(src[0]),
        .i_reset_pin(1'b1), .i_stop_exec(stp), .i_wait_exec(wt),
        .i_break(brk), .i_irq(irq), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
        .o_cpu_clock_en(cpu_en), .o_periph_clock_en(per_en),
        .o_bus_phase1(ph1), .o_bus_phase2(ph2), .o_pll_select(psel),
        .o_reset_pin_out(pout), .o_reset_pin_oe_n(poe_n),
        .o_internal_reset(internal_reset), .o_irq_any(any)
    );
    sbcc_cpu_model i_sbcc_cpu_model
    (
        .i_clock(clk), .i_resetn(rstn), .i_cpu_clock_en(cpu_en),
        .i_cmd(cmd), .o_stop_exec(stp), .o_wait_exec(wt)
    );

    // ==========================================
    // tasks
    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr_s} <= {a, d, 1'b1};
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    // data are taken in the single cycle after the strobe
    task automatic rd(logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        {addr, rd_s} <= {a, 1'b1};
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task automatic waitc(input logic l, output int n);
        n = 0;
        while (cpu_en !== l)
        begin
            @(posedge clk);
            #1 n++;
            if (n > 3000)
            begin
                errors++;
                final_report();
            end
        end
    endtask : waitc

    // synchroniser lag and reference phase allow a small slack
    function automatic logic near(int n, int falls);
        return n >= falls * 4 - 12 && n <= falls * 4 + 12;
    endfunction : near

    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    // ==========================================
    // main sequence
    initial
    begin
        logic [7:0] v;
        int         n;
        int         k;
        logic       q;
        logic       r;
        void'($urandom(32'h9869));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        #1 check("hold", {internal_reset, poe_n, pout}, 3'b100);
        waitc(1'b1, n);
        check("holdoff", near(n, 64), 1'b1);
        check("run", {per_en, poe_n}, 2'b11);
        rd(16'hfe01, v);
        check("cause", v, 8'h80);
        rd(16'hfe02, v);
        check("unmapped", v, 8'h00);
        repeat (4)
        begin
            k = $urandom;
            wr(16'hfe03, k[7:0]);
            pll <= k[8];
            rd(16'hfe03, v);
            check("flag_ctrl", v, k[7:0]);
            check("pll_sel", psel, k[8]);
        end
        k = 0;
        n = 0;
        q = ph1;
        r = ph2;
        // bus period is four reference periods, sixteen clocks
        repeat (80)
        begin
            @(posedge clk);
            #1 k += int'(ph1 & ~q);
            n += int'(ph2 & ~r);
            q = ph1;
            r = ph2;
        end
        check("bus_rate", k inside {[4:6]}, 1'b1);
        check("bus_rate2", n inside {[4:6]}, 1'b1);
        @(posedge clk);
        irq <= $urandom | 32'h1;
        repeat (4) @(posedge clk);
        #1 check("irq_any", any, 1'b1);
        for (int b = 0; b < 4; b++)
        begin
            rd(16'hfe08 + 16'(b), v);
            check("irq_pend", v, irq[8*b+:8]);
        end
        @(posedge clk);
        irq <= 32'h0;
        repeat (4) @(posedge clk);
        cmd <= 2'h2;
        @(posedge clk);
        cmd <= 2'h0;
        waitc(1'b0, n);
        rd(16'hfe05, v);
        check("wait", {per_en, v}, 9'h108);
        @(posedge clk);
        brk <= 1'b1;
        @(posedge clk);
        brk <= 1'b0;
        waitc(1'b1, n);
        // short recovery first, so a stale count would cut the long one
        for (int s = 1; s >= 0; s--)
        begin
            wr(16'hfe04, 8'(s));
            cmd <= 2'h1;
            @(posedge clk);
            cmd <= 2'h0;
            waitc(1'b0, n);
            repeat (40) @(posedge clk);
            #1 check("stop_off", {cpu_en, per_en}, 2'b00);
            // interrupt wakes the short pass, software wake bit the long
            @(posedge clk);
            if (s)
                irq <= 32'h1;
            else
                wr(16'hfe04, 8'h02);
            waitc(1'b1, n);
            check("stop_len", near(n, s ? 32 : 64), 1'b1);
            @(posedge clk);
            irq <= 32'h0;
            rd(16'hfe04, v);
            check("wake_clr", v, 8'(s));
        end
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            src <= 2'(1 << i);
            @(posedge clk);
            src <= 2'b00;
            repeat (4) @(posedge clk);
            #1 check("src_hold", {internal_reset, poe_n, cpu_en}, 3'b100);
            waitc(1'b1, n);
            check("src_time", near(n, 64), 1'b1);
            rd(16'hfe01, v);
            check("src_cause", v[i ? 7 : 1], 1'b1);
        end
        final_report();
    end
endmodule : testbench
